/* File: design/pms_chan.sv */
// Per-channel chopper accumulator, peak and random capture, averaging window
`timescale 1ns/1ps
module pms_chan
    import pms_pkg::*;
#(
    parameter int SW = SAMP_W,
    parameter int AW = DAT_W,
    parameter int DEPTH = 16,
    parameter int CW = CNT_W
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic idle,
    input wire logic en,
    input wire logic inv,
    input wire logic s_valid,
    input wire logic [SW-1:0] s_data,
    input wire logic rnd_bit,
    input wire logic clr,
    input wire logic push,
    input wire logic [CW-1:0] wlen,
    output logic [AW-1:0] sum,
    output logic [SW-1:0] pk,
    output logic [SW-1:0] rn
);
    localparam int IW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] acc;
        logic [SW-1:0] pk_run;
        logic [SW-1:0] rn_run;
        logic [AW-1:0] sum;
        logic [SW-1:0] pk;
        logic [SW-1:0] rn;
        logic [DEPTH-1:0][AW-1:0] hist;
        logic [IW-1:0] wp;
        logic [CW-1:0] fill;
    } pms_chan_st_type;
    pms_chan_st_type s;
    pms_chan_st_type n;
    logic [AW-1:0] samp;
    logic [AW-1:0] meas;

    always_comb begin
        n = s;
        samp = AW'(s_data);
        meas = '0;
        if (idle) begin
            n.acc = '0;
            n.pk_run = '0;
            n.rn_run = '0;
        end else if (en && s_valid) begin
            n.acc = inv ? s.acc - samp : s.acc + samp; // [RQ23]
            if (s_data > s.pk_run) begin
                n.pk_run = s_data;
            end
            if (rnd_bit) begin
                n.rn_run = s_data;
            end
        end
        // Window only; acc may already hold the next measurement
        if (clr) begin
            n.sum = '0;
            n.hist = '0;
            n.wp = '0;
            n.fill = '0;
        end
        if (push) begin
            meas = n.acc;
            n.pk = n.pk_run;
            n.rn = n.rn_run;
            if (s.fill >= wlen) begin
                n.sum = s.sum + meas - s.hist[s.wp]; // [RQ22]
            end else begin
                n.sum = s.sum + meas;
                n.fill = s.fill + 1'b1;
            end
            n.hist[s.wp] = meas;
            n.wp = (CW'(s.wp) + 1'b1 >= wlen) ? '0 : s.wp + 1'b1;
            n.acc = '0;
            n.pk_run = '0;
            n.rn_run = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign sum = s.sum;
    assign pk = s.pk;
    assign rn = s.rn;
endmodule // pms_chan

/* File: design/pms_pkg.sv */
// Package: constants, register map and types of the measurement sequencer
// Summary of operation
// [RQ1] Average mode: noninverted then inverted phase, each one aperture long.
// [RQ2] Repeat control: one result after average-count measurements, then restart.
// [RQ3] Repeat control, average mode: sync stays high over the whole cycle.
// [RQ4] Moving control, average mode: each measurement waits for a trigger.
// [RQ5] Moving control: result after every measurement, settled once count reached.
// [RQ6] Stop and go idle once handled triggers reach the trigger count.
// [RQ7] Average mode, count one: one noninverted phase, settled result, idle.
// [RQ8] Host sets the trace average count to two before trace runs.
// [RQ9] Host selects repeat control for trace averaging.
// [RQ10] Trace mode: each phase starts on a trigger, lasts trace time, sync high.
// [RQ11] Trace mode: two phases per measurement, result after count measurements.
// [RQ12] Trace, moving control: result every measurement, settled once count reached.
// [RQ13] Trace mode, count one: one noninverted phase, settled result, idle.
// [RQ14] Single shot sequences like continuous but never restarts the cycle.
// [RQ15] Two modes, average and trace; average selected after reset.
// [RQ16] Trace point duration is total trace time divided by point count.
// [RQ17] Per-channel result read returns only that channel, channels one to three.
// [RQ18] All-channel read returns every channel result separated by commas.
// [RQ19] Measurand: average, peak or random sample per mode; average after reset.
// [RQ20] Host picks the measurand before starting the measurement.
// [RQ21] Idle after reset; start waits, trigger measures, then repeat or idle.
// [RQ22] Moving result is a window over the last average-count measurements; the window is capped at DEPTH (16) here.
// [RQ23] Measurement is noninverted phase output minus inverted phase output.
// [RQ24] One-cycle result valid pulse with a settled flag.
package pms_pkg;
    localparam int CLK_MHZ = 125;
    localparam int APER_RST_US = 20000;
    localparam int APER_RST_CYC = APER_RST_US * CLK_MHZ;
    localparam int NCH = 3;
    localparam int DAT_W = 32;
    localparam int CNT_W = 16;
    localparam int SAMP_W = 16;
    localparam int ADDR_W = 4;
    localparam int DIV_CW = 6;
    localparam logic [ADDR_W-1:0] A_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] A_CMD = 4'h1;
    localparam logic [ADDR_W-1:0] A_AVG = 4'h2;
    localparam logic [ADDR_W-1:0] A_TAVG = 4'h3;
    localparam logic [ADDR_W-1:0] A_TRIG = 4'h4;
    localparam logic [ADDR_W-1:0] A_APER = 4'h5;
    localparam logic [ADDR_W-1:0] A_TTIME = 4'h6;
    localparam logic [ADDR_W-1:0] A_PTS = 4'h7;
    localparam logic [ADDR_W-1:0] A_PLEN = 4'h8;
    localparam logic [ADDR_W-1:0] A_RES1 = 4'h9;
    localparam logic [ADDR_W-1:0] A_RES2 = 4'ha;
    localparam logic [ADDR_W-1:0] A_RES3 = 4'hb;
    localparam logic [ADDR_W-1:0] A_ALL = 4'hc;
    localparam logic [ADDR_W-1:0] A_STAT = 4'hd;
    localparam int B_MODE = 0;
    localparam int B_TERM = 1;
    localparam int B_FEED = 2;
    localparam int FEED_W = 3;
    localparam int B_CONT = 5;
    localparam int B_START = 0;
    localparam int B_ABORT = 1;
    localparam int B_TRIG = 2;
    localparam logic [CNT_W-1:0] AVG_RST = 16'h0001;
    localparam logic [CNT_W-1:0] TAVG_RST = 16'h0001;
    localparam logic [CNT_W-1:0] TRIG_RST = 16'h0000;
    localparam logic [CNT_W-1:0] PTS_RST = 16'h0001;
    localparam logic [DAT_W-1:0] SEP_WORD = 32'h0000_002c;
    localparam logic [2:0] ALL_LAST = 3'h4;
    localparam logic [DIV_CW-1:0] DIV_LAST = 6'h1f;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} pms_state_type;
    typedef enum logic [2:0] {
        FEED_AVG, FEED_PEAK, FEED_RAND, FEED_TRACE, FEED_PTRACE, FEED_RTRACE
    } pms_feed_type;
endpackage

/* File: design/pms_seq.sv */
// Measurement sequencer top: register port, trigger, chopper and results
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module pms_seq
    import pms_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int APER_CYC = APER_RST_CYC,
    parameter int TTIME_CYC = 1000
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DAT_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DAT_W-1:0] reg_rdata,
    input wire logic trig_pin,
    input wire logic det_valid,
    input wire logic [NCH*SAMP_W-1:0] det_data,
    output logic trig_sync,
    output logic chop_inv,
    output logic point_tick,
    output logic res_valid,
    output logic res_settled
);
    typedef struct packed {
        pms_state_type st;
        logic inv;
        logic sync;
        logic ptick;
        logic rvalid;
        logic rsettled;
        logic res_pend;
        logic pend_set;
        logic rep_clr;
        logic t1;
        logic t2;
        logic t3;
        logic mode;
        logic term;
        logic cont;
        pms_feed_type feed;
        logic [CNT_W-1:0] avg_cnt;
        logic [CNT_W-1:0] tavg_cnt;
        logic [CNT_W-1:0] trig_lim;
        logic [CNT_W-1:0] trig_cnt;
        logic [CNT_W-1:0] meas_cnt;
        logic [CNT_W-1:0] fill;
        logic [CNT_W-1:0] pts;
        logic [DAT_W-1:0] aper;
        logic [DAT_W-1:0] ttime;
        logic [DAT_W-1:0] plen;
        logic [DAT_W-1:0] tmr;
        logic [DAT_W-1:0] ptmr;
        logic [DAT_W-1:0] rdata;
        logic div_busy;
        logic [DIV_CW-1:0] div_cnt;
        logic [DAT_W-1:0] div_rem;
        logic [DAT_W-1:0] div_q;
        logic [NCH-1:0][DAT_W-1:0] res;
        logic [2:0] all_idx;
        logic [15:0] lfsr;
    } pms_seq_st_type;

    pms_seq_st_type s;
    pms_seq_st_type n;
    logic [CNT_W-1:0] ac;
    logic ac1;
    logic [CNT_W-1:0] win;
    logic [DAT_W-1:0] len;
    logic [DAT_W-1:0] len_m1;
    logic [DAT_W-1:0] plen_m1;
    logic trig;
    logic hit;
    logic last;
    logic push_c;
    logic clr_c;
    logic idle_c;
    logic en_c;
    logic sw_start;
    logic sw_abort;
    logic sw_trig;
    logic div_go;
    logic [DAT_W-1:0] rem_sh;
    logic [DAT_W-1:0] ch_sum [NCH];
    logic [SAMP_W-1:0] ch_pk [NCH];
    logic [SAMP_W-1:0] ch_rn [NCH];

    ////////////////////////////////////////////////////////////////////////
    // Derived settings

    always_comb begin
        ac = s.mode ? s.tavg_cnt : s.avg_cnt;
        ac1 = (ac <= CNT_W'(1));
        // Window is bounded by the history depth of each channel
        if (ac1) begin
            win = CNT_W'(1);
        end else if (ac > CNT_W'(DEPTH)) begin
            win = CNT_W'(DEPTH);
        end else begin
            win = ac;
        end
        len = s.mode ? s.ttime : s.aper; // [RQ1] [RQ10]
        len_m1 = (len == '0) ? '0 : len - 1'b1;
        plen_m1 = (s.plen == '0) ? '0 : s.plen - 1'b1;
        trig = (s.t2 & ~s.t3) | sw_trig;
        hit = (s.trig_lim != '0) && (s.trig_cnt >= s.trig_lim);
        last = (s.meas_cnt + 1'b1) >= ac;
        idle_c = (s.st == ST_IDLE);
        en_c = (s.st == ST_RUN);
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        pms_chan #(
            .SW(SAMP_W),
            .AW(DAT_W),
            .DEPTH(DEPTH),
            .CW(CNT_W)
        ) u_ch (
            .clk_sys(clk_sys),
            .rst(rst),
            .idle(idle_c),
            .en(en_c),
            .inv(s.inv),
            .s_valid(det_valid),
            .s_data(det_data[c*SAMP_W +: SAMP_W]),
            .rnd_bit(s.lfsr[0]),
            .clr(clr_c),
            .push(push_c),
            .wlen(win),
            .sum(ch_sum[c]),
            .pk(ch_pk[c]),
            .rn(ch_rn[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        n = s;
        n.t1 = trig_pin;
        n.t2 = s.t1;
        n.t3 = s.t2;
        n.lfsr = {1'b0, s.lfsr[15:1]} ^ (s.lfsr[0] ? LFSR_TAPS : '0);
        n.rdata = '0;
        n.rvalid = 1'b0;
        n.ptick = 1'b0;
        n.res_pend = 1'b0;
        push_c = 1'b0;
        clr_c = 1'b0;
        sw_start = 1'b0;
        sw_abort = 1'b0;
        sw_trig = 1'b0;
        div_go = 1'b0;
        rem_sh = '0;
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: begin
                    // Frozen while busy: measurand fixed before the start
                    if (s.st == ST_IDLE) begin // [RQ20]
                        n.mode = reg_wdata[B_MODE]; // [RQ15]
                        n.term = reg_wdata[B_TERM];
                        n.cont = reg_wdata[B_CONT];
                        if (reg_wdata[B_FEED +: FEED_W] <= FEED_RTRACE) begin
                            n.feed = pms_feed_type'(
                                reg_wdata[B_FEED +: FEED_W]); // [RQ19]
                        end
                    end
                end
                A_CMD: begin
                    sw_start = reg_wdata[B_START];
                    sw_abort = reg_wdata[B_ABORT];
                    sw_trig = reg_wdata[B_TRIG];
                end
                A_AVG: n.avg_cnt = reg_wdata[CNT_W-1:0];
                A_TAVG: n.tavg_cnt = reg_wdata[CNT_W-1:0];
                A_TRIG: n.trig_lim = reg_wdata[CNT_W-1:0];
                A_APER: n.aper = reg_wdata;
                A_TTIME: begin
                    n.ttime = reg_wdata;
                    div_go = 1'b1;
                end
                A_PTS: begin
                    // Zero points would divide by zero, so it is refused
                    if (reg_wdata[CNT_W-1:0] != '0) begin
                        n.pts = reg_wdata[CNT_W-1:0];
                        div_go = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                A_CTRL: n.rdata = DAT_W'({s.cont, s.feed, s.term, s.mode});
                A_AVG: n.rdata = DAT_W'(s.avg_cnt);
                A_TAVG: n.rdata = DAT_W'(s.tavg_cnt);
                A_TRIG: n.rdata = DAT_W'(s.trig_lim);
                A_APER: n.rdata = s.aper;
                A_TTIME: n.rdata = s.ttime;
                A_PTS: n.rdata = DAT_W'(s.pts);
                A_PLEN: n.rdata = s.plen;
                A_RES1: n.rdata = s.res[0]; // [RQ17]
                A_RES2: n.rdata = s.res[1]; // [RQ17]
                A_RES3: n.rdata = s.res[2]; // [RQ17]
                A_ALL: begin
                    n.rdata = s.all_idx[0] ? SEP_WORD
                                           : s.res[s.all_idx[2:1]]; // [RQ18]
                    n.all_idx = (s.all_idx == ALL_LAST) ? '0
                                                        : s.all_idx + 1'b1;
                end
                A_STAT: n.rdata = DAT_W'({s.trig_cnt, s.rsettled, s.inv, s.st});
                default: n.rdata = '0;
            endcase
        end
        // Bit-serial divider, one quotient bit per cycle
        if (div_go) begin
            n.div_busy = 1'b1;
            n.div_cnt = '0;
            n.div_rem = '0;
            n.div_q = n.ttime;
        end else if (s.div_busy) begin
            rem_sh = {s.div_rem[DAT_W-2:0], s.div_q[DAT_W-1]};
            n.div_q = {s.div_q[DAT_W-2:0], 1'b0};
            if (rem_sh >= DAT_W'(s.pts)) begin
                n.div_rem = rem_sh - DAT_W'(s.pts);
                n.div_q[0] = 1'b1;
            end else begin
                n.div_rem = rem_sh;
            end
            n.div_cnt = s.div_cnt + 1'b1;
            if (s.div_cnt == DIV_LAST) begin
                n.div_busy = 1'b0;
                n.plen = n.div_q; // [RQ16]
            end
        end
        // Results are taken one cycle after the channel window update
        if (s.res_pend) begin
            n.rvalid = 1'b1; // [RQ24]
            n.rsettled = s.pend_set;
            for (int c = 0; c < NCH; c++) begin
                case (s.feed)
                    FEED_PEAK, FEED_PTRACE: n.res[c] = DAT_W'(ch_pk[c]);
                    FEED_RAND, FEED_RTRACE: n.res[c] = DAT_W'(ch_rn[c]);
                    default: n.res[c] = ch_sum[c];
                endcase
            end
            clr_c = s.rep_clr; // [RQ2]
            n.rep_clr = 1'b0;
        end
        case (s.st)
            ST_IDLE: begin
                if (sw_start) begin // [RQ21]
                    n.st = ST_WAIT;
                    n.inv = 1'b0;
                    n.meas_cnt = '0;
                    n.fill = '0;
                    n.trig_cnt = '0;
                    clr_c = 1'b1;
                end
            end
            ST_WAIT: begin
                // Limit met between trace phases: later triggers refused
                if (hit) begin
                    n.st = ST_IDLE; // [RQ6]
                end else if (trig) begin // [RQ4] [RQ10] [RQ21]
                    n.st = ST_RUN;
                    n.sync = 1'b1;
                    n.trig_cnt = s.trig_cnt + 1'b1;
                    n.tmr = len_m1;
                    n.ptmr = plen_m1;
                end
            end
            ST_RUN: begin
                if (s.mode) begin
                    if (s.ptmr == '0) begin
                        n.ptick = 1'b1; // [RQ16]
                        n.ptmr = plen_m1;
                    end else begin
                        n.ptmr = s.ptmr - 1'b1;
                    end
                end
                if (s.tmr != '0) begin
                    n.tmr = s.tmr - 1'b1;
                end else if (ac1) begin
                    push_c = 1'b1; // [RQ7] [RQ13]
                    n.res_pend = 1'b1;
                    n.pend_set = 1'b1;
                    n.st = ST_IDLE;
                    n.sync = 1'b0;
                end else if (!s.inv) begin
                    n.inv = 1'b1; // [RQ1]
                    n.tmr = len_m1;
                    n.ptmr = plen_m1;
                    if (s.mode) begin
                        n.st = ST_WAIT; // [RQ10]
                        n.sync = 1'b0;
                    end
                end else begin
                    push_c = 1'b1; // [RQ11]
                    n.inv = 1'b0;
                    n.meas_cnt = last ? '0 : s.meas_cnt + 1'b1;
                    n.fill = (s.fill >= ac) ? s.fill : s.fill + 1'b1;
                    if (s.term) begin
                        n.res_pend = 1'b1; // [RQ5] [RQ12]
                        n.pend_set = (s.fill + 1'b1) >= ac;
                    end else if (last) begin
                        n.res_pend = 1'b1; // [RQ2]
                        n.pend_set = 1'b1;
                        n.rep_clr = 1'b1;
                    end
                    // An average-mode repeat cycle is never cut by the trigger limit
                    if (!s.mode && !s.term && !last) begin
                        n.tmr = len_m1; // [RQ3]
                    end else if ((last && !s.cont) || hit) begin
                        n.st = ST_IDLE; // [RQ6] [RQ14]
                        n.sync = 1'b0;
                    end else begin
                        n.st = ST_WAIT; // [RQ4]
                        n.sync = 1'b0;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
                n.sync = 1'b0;
            end
        endcase
        if (sw_abort) begin
            n.st = ST_IDLE;
            n.sync = 1'b0;
            n.inv = 1'b0;
            n.res_pend = 1'b0;
            push_c = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.st <= ST_IDLE; // [RQ21]
            s.feed <= FEED_AVG; // [RQ19]
            s.avg_cnt <= AVG_RST;
            s.tavg_cnt <= TAVG_RST;
            s.trig_lim <= TRIG_RST;
            s.pts <= PTS_RST;
            s.aper <= DAT_W'(APER_CYC);
            s.ttime <= DAT_W'(TTIME_CYC);
            s.plen <= DAT_W'(TTIME_CYC);
            s.lfsr <= LFSR_SEED;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign trig_sync = s.sync;
    assign chop_inv = s.inv;
    assign point_tick = s.ptick;
    assign res_valid = s.rvalid;
    assign res_settled = s.rsettled;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_sync_run: // [RQ3]
    assert property (@(posedge clk_sys) disable iff (rst)
        s.sync == (s.st == ST_RUN))
        else $error("sync does not match the run state");

    a_chop_second: // [RQ1]
    assert property (@(posedge clk_sys) disable iff (rst)
        $rose(s.inv) |-> $past(s.st == ST_RUN) && $past(s.tmr == '0))
        else $error("inverted phase began before the first ended");

    a_phase_len: // [RQ1]
    assert property (@(posedge clk_sys) disable iff (rst)
        (s.st == ST_RUN && s.tmr == '0 && !s.inv && !ac1 && !s.mode
         && !sw_abort) |=> s.inv && s.tmr == $past(len_m1))
        else $error("inverted phase length differs from first");

    a_rep_settled: // [RQ2]
    assert property (@(posedge clk_sys) disable iff (rst)
        (s.rvalid && !s.term) |-> s.rsettled)
        else $error("repeat result not flagged settled");

    a_moving_each: // [RQ5]
    assert property (@(posedge clk_sys) disable iff (rst)
        (s.st == ST_RUN && s.tmr == '0 && s.inv && s.term && !sw_abort)
        |-> ##2 s.rvalid)
        else $error("moving measurement gave no result");

    a_trig_limit: // [RQ6]
    assert property (@(posedge clk_sys) disable iff (rst)
        (s.trig_lim != '0) |-> s.trig_cnt <= s.trig_lim)
        else $error("triggers handled beyond the trigger count");

    a_single_idle: // [RQ7]
    assert property (@(posedge clk_sys) disable iff (rst)
        (s.st == ST_RUN && s.tmr == '0 && ac1 && !sw_abort)
        |=> s.st == ST_IDLE && !s.sync ##1 s.rvalid && s.rsettled)
        else $error("count one run did not end settled and idle");

    a_trace_wait: // [RQ10]
    assert property (@(posedge clk_sys) disable iff (rst)
        (s.mode && s.st == ST_RUN && s.tmr == '0 && !s.inv && !ac1
         && !sw_abort)
        |=> s.st == ST_WAIT && !s.sync)
        else $error("trace phase did not wait for its trigger");

    a_valid_pulse: // [RQ24]
    assert property (@(posedge clk_sys) disable iff (rst)
        s.rvalid |=> !s.rvalid)
        else $error("result valid longer than one cycle");
endmodule // pms_seq

/* File: verif/pms_det_model.sv */
// Detector model: chopped constant power on the three channels
`timescale 1ns/1ps
module pms_det_model
    import pms_pkg::*;
(
    input wire logic chop_inv,
    output logic det_valid,
    output logic [NCH*SAMP_W-1:0] det_data
);
    // Inverted phase reads zero, so a measurement is the N phase sum
    assign det_valid = 1'b1;
    assign det_data = chop_inv ? '0 : {16'h0033, 16'h0022, 16'h0011};
endmodule // pms_det_model

/* File: verif/pms_seq_tb.sv */
// Testbench of the measurement sequencer over its register port
`timescale 1ns/1ps
module pms_seq_tb;
    import pms_pkg::*;
    localparam int LEN = 8;
    logic clk_sys, rst, reg_wr, reg_rd, trig_pin, det_valid, st;
    logic trig_sync, chop_inv, point_tick, res_valid, res_settled;
    logic [ADDR_W-1:0] reg_addr;
    logic [DAT_W-1:0] reg_wdata, reg_rdata, d;
    logic [DAT_W-1:0] ex [5];
    logic [NCH*SAMP_W-1:0] det_data;
    int failures = 0, n_compared = 0, cyc = 0, sc, tc;
    pms_seq #(.APER_CYC(LEN), .TTIME_CYC(LEN)) pms_seq_inst (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trig_pin(trig_pin), .det_valid(det_valid),
        .det_data(det_data), .trig_sync(trig_sync), .chop_inv(chop_inv),
        .point_tick(point_tick), .res_valid(res_valid),
        .res_settled(res_settled));
    pms_det_model pms_det_model_inst (.chop_inv(chop_inv),
        .det_valid(det_valid), .det_data(det_data));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Whole run needs a few hundred cycles; this only cuts a hang
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
            failures++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Trigger by pin or command, then count sync and ticks until a result
    task automatic go(input bit pin);
        int n;
        n = 0;
        sc = 0;
        tc = 0;
        if (pin) begin
            @(posedge clk_sys);
            trig_pin <= 1'b1;
            repeat (2) @(posedge clk_sys);
            trig_pin <= 1'b0;
        end else
            wr(A_CMD, 32'h4);
        while (res_valid !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
            sc += int'(trig_sync === 1'b1);
            tc += int'(point_tick === 1'b1);
        end
        st = res_settled;
        chk("result wait", 32'(n < 300), 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        trig_pin = 1'b0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(A_CTRL); chk("ctrl reset", d, 32'h0);
        rd(A_AVG); chk("avg reset", d, 32'h1);
        rd(A_TRIG); chk("trig reset", d, 32'h0);
        rd(A_STAT); chk("status reset", d, 32'h0);
        rd(4'hf); chk("unmapped", d, 32'h0);
        $display("test reset done");
        // Count one: a single noninverted phase, then idle
        wr(A_APER, LEN);
        wr(A_CMD, 32'h1);
        go(1'b0);
        chk("ac1 sync", sc, LEN);
        chk("ac1 settled", 32'(st), 32'h1);
        rd(A_STAT); chk("ac1 idle", 32'(d[1:0]), 32'h0);
        ex = '{LEN*17, SEP_WORD, LEN*34, SEP_WORD, LEN*51};
        for (int i = 0; i < 5; i++) begin
            rd(A_ALL); chk("all", d, ex[i]);
        end
        rd(A_RES3); chk("res ch3", d, ex[4]);
        wr(A_CTRL, 32'h04);
        wr(A_CMD, 32'h1);
        go(1'b1);
        rd(A_RES2); chk("peak ch2", d, 32'h22);
        $display("test count one done");
        // Repeat control, continuous: sync spans all four measurements
        wr(A_AVG, 32'h4);
        wr(A_CTRL, 32'h20);
        wr(A_CMD, 32'h1);
        go(1'b0);
        chk("rep sync", sc, 8*LEN);
        rd(A_RES1); chk("rep sum", d, 4*LEN*17);
        rd(A_STAT); chk("rep restart", 32'(d[1:0]), 32'h1);
        wr(A_CMD, 32'h2);
        rd(A_STAT); chk("abort idle", 32'(d[1:0]), 32'h0);
        $display("test repeat done");
        // Moving control: result per trigger, stop at trigger count
        wr(A_TRIG, 32'h6);
        wr(A_CTRL, 32'h22);
        wr(A_CMD, 32'h1);
        for (int k = 1; k <= 6; k++) begin
            go(k[0]);
            chk("mov sync", sc, 2*LEN);
            chk("mov settled", 32'(st), 32'(k >= 4));
            rd(A_RES1); chk("mov sum", d, (k < 4 ? k : 4)*LEN*17);
        end
        rd(A_STAT); chk("mov idle", 32'(d[1:0]), 32'h0);
        $display("test moving done");
        // Trace, single shot: every phase needs its own trigger
        wr(A_TAVG, 32'h2);
        wr(A_PTS, 32'h4);
        wr(A_TTIME, LEN);
        wr(A_CTRL, 32'h0d);
        repeat (33) @(posedge clk_sys);
        rd(A_PLEN); chk("point len", d, LEN/4);
        wr(A_CMD, 32'h1);
        repeat (3) begin
            wr(A_CMD, 32'h4);
            repeat (LEN + 4) @(posedge clk_sys);
        end
        go(1'b0);
        chk("trace sync", sc, LEN);
        chk("trace ticks", tc, 4);
        chk("trace settled", 32'(st), 32'h1);
        rd(A_STAT); chk("trace idle", 32'(d[1:0]), 32'h0);
        $display("test trace done");
        end_of_test();
    end
endmodule // pms_seq_tb
